/* File: shared/radio_spi_map.vh */
`ifndef RADIO_SPI_MAP_VH
`define RADIO_SPI_MAP_VH

// control word layout: bit 7 read, bit 6 packet buffer, bits 5:0 direct address
`define CTL_READ_BIT 7
`define CTL_BUF_BIT 6
`define CTL_ADDR_MSB 5
// direct address that escapes to an indirect register (address byte follows)
`define CTL_INDIRECT_ESC 6'h3F

// packet buffer geometry
`define BUF_DEPTH 128
`define BUF_AW 7

// write fifo geometry and entry layout {buf, indirect, addr[7:0], data[7:0]}
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define FIFO_W 18
`define ENT_BUF_BIT 17
`define ENT_IND_BIT 16
`define ENT_ADDR_MSB 15
`define ENT_ADDR_LSB 8

// widths of the core-side status and byte paths
`define IRQ_W 8
`define BYTE_W 8

// reset values, and the bit count of the last bit of a byte
`define RST_BYTE 8'h00
`define RST_ADDR 8'h00
`define RST_CNT 3'h0
`define LAST_BIT 3'h7

// link clock period seen in the bench, and the core clock period, in ns
`define SCLK_PERIOD_NS 800
`define CLK_PERIOD_NS 100

`endif

/* File: src/byte_ram.v */
`timescale 1ns/100ps

// two-port byte memory: one write port, one read port with registered data
module byte_ram #(
  parameter WIDTH = 8,
  parameter DEPTH = 128,
  parameter AW = 7
) (
  // clock
  input wire clk,
  // write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  // read port
  input wire re,
  input wire [AW-1:0] raddr,
  output reg [WIDTH-1:0] rdata_q
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage, no reset so it maps onto ram cells

  // write and registered read; read during write of same word returns old data
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata_q <= mem[raddr];
    end
  end

endmodule // byte_ram

/* File: src/sync_fifo.v */
`timescale 1ns/100ps

// small synchronous fifo with valid/ready on both sides
module sync_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // entry storage
  reg [AW-1:0] wr_ptr_q; // next slot to fill
  reg [AW-1:0] rd_ptr_q; // oldest entry
  reg [AW:0] count_q; // entries held, one bit wider than the pointers
  wire push; // accepted write
  wire pop; // accepted read

  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage is written without reset
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers and occupancy; push and pop may share a cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // sync_fifo

/* File: src/radio_spi_slave_port.v */
// Operation
// - slave only; never drives clock or select
// - direct and indirect registers, single or burst
// - packet buffer single byte or unlimited burst
// - serial clock unrelated to core clock
// - all domain crossing kept inside port
// - works in every power mode but reset
// - hibernate still reaches buffer and registers
// - first byte is control word with address
// - top interrupt status shifts out first
// - burst address increments after each byte
// - whole buffer fits one burst
// - buffer is 128 shared bytes
// - protect blocks receive writes, not serial writes
`timescale 1ns/100ps
`include "radio_spi_map.vh"

module radio_spi_slave_port #(
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter FIFO_AW = `FIFO_AW,
  parameter BUF_DEPTH = `BUF_DEPTH,
  parameter BUF_AW = `BUF_AW
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // serial link pins: inputs from outside the clock domain, outputs registered on clk
  input wire ssel_n,
  input wire sclk,
  input wire mosi,
  output reg miso_q,
  output reg miso_oe_q,
  // status shown during every control word
  input wire [`IRQ_W-1:0] top_irq_status,
  // register write towards the core
  output reg reg_wr_q,
  output reg reg_wr_indirect_q,
  output reg [7:0] reg_wr_addr_q,
  output reg [7:0] reg_wr_data_q,
  input wire reg_wr_ready,
  // register read from the core, data valid the cycle after the strobe
  output reg reg_rd_q,
  output reg reg_rd_indirect_q,
  output reg [7:0] reg_rd_addr_q,
  input wire [7:0] reg_rdata,
  // receive path into the packet buffer
  input wire buffer_rx_protect,
  input wire rx_wr_en,
  input wire [BUF_AW-1:0] rx_wr_addr,
  input wire [7:0] rx_wr_data,
  // port status
  output reg overrun_q,
  output reg spi_active_q
);

  // transaction states
  localparam ST_IDLE = 2'b00;
  localparam ST_CTRL = 2'b01;
  localparam ST_ADDR = 2'b10;
  localparam ST_DATA = 2'b11;

  // next address of a burst; the buffer wraps inside its own size
  function [7:0] next_addr;
    input [7:0] a;
    input is_buf;
    begin
      if (is_buf) begin
        next_addr = {1'b0, a[6:0] + 7'h01};
      end else begin
        next_addr = a + 8'h01;
      end
    end
  endfunction

  // pin synchronisers: first stage feeds only the second
  reg cs_n_s1_q; // select, first stage
  reg cs_n_s2_q; // select, second stage
  reg sclk_s1_q; // clock, first stage
  reg sclk_s2_q; // clock, second stage
  reg sclk_d_q; // delayed copy for edge detection
  reg mosi_s1_q; // data in, first stage
  reg mosi_s2_q; // data in, second stage
  reg cs_act_d_q; // select seen last cycle

  // shift engine
  reg [1:0] state_q; // transaction phase
  reg [2:0] bit_cnt_q; // bits of the current byte taken
  reg [7:0] shift_in_q; // received bits
  reg [7:0] shift_out_q; // byte on its way out, msb on the wire
  reg read_q; // current access reads
  reg buf_q; // current access targets the packet buffer
  reg ind_q; // current access targets an indirect register
  reg [7:0] addr_q; // current target address

  // read prefetch
  reg fetch_q; // one-cycle fetch strobe
  reg capture_q; // fetched data arrives this cycle
  reg capture_reg_q; // core read data arrives this cycle, one after the buffer's
  reg [7:0] rd_data_q; // next byte to send during a read

  // write path into the fifo
  reg push_q; // one-cycle push strobe
  reg [`FIFO_W-1:0] push_data_q; // entry being pushed

  wire cs_act; // select asserted, synchronised
  wire cs_start; // first cycle of a selection
  wire sclk_rise; // sampling edge seen
  wire sclk_fall; // shifting edge seen
  wire [7:0] byte_in; // byte complete with the bit now sampled
  wire byte_done; // last bit of a byte sampled this cycle
  wire [7:0] next_out; // what the next byte boundary sends
  wire fifo_in_ready; // fifo can take the push
  wire fifo_out_valid; // fifo holds a write
  wire fifo_out_ready; // drain takes the oldest write
  wire [`FIFO_W-1:0] fifo_out_data; // oldest write
  wire drain_buf; // oldest write targets the buffer
  wire rx_take; // receive write wins the buffer this cycle
  wire ram_we; // buffer write strobe
  wire [BUF_AW-1:0] ram_waddr; // buffer write address
  wire [7:0] ram_wdata; // buffer write data
  wire [7:0] ram_rdata; // registered buffer read data

  assign cs_act = ~cs_n_s2_q;
  assign cs_start = cs_act & ~cs_act_d_q;
  // mode 0: sample on rising, shift on falling
  assign sclk_rise = sclk_s2_q & ~sclk_d_q;
  assign sclk_fall = ~sclk_s2_q & sclk_d_q;
  assign byte_in = {shift_in_q[6:0], mosi_s2_q};
  assign byte_done = sclk_rise & (bit_cnt_q == `LAST_BIT);
  // writes and address bytes send zeros after the status byte
  assign next_out = (read_q && state_q == ST_DATA) ? rd_data_q : `RST_BYTE;

  // two-flop synchronisers for the link pins; no edge reaches the core unsynchronised
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_n_s1_q <= 1'b1;
      cs_n_s2_q <= 1'b1;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_d_q <= 1'b0;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
      cs_act_d_q <= 1'b0;
    end else begin
      cs_n_s1_q <= ssel_n;
      cs_n_s2_q <= cs_n_s1_q;
      sclk_s1_q <= sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_d_q <= sclk_s2_q;
      mosi_s1_q <= mosi;
      mosi_s2_q <= mosi_s1_q;
      cs_act_d_q <= cs_act;
    end
  end

  // byte engine: control word, optional address byte, then data bytes
  // sclk and select are only ever inputs here, the port never starts a transfer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= `RST_CNT;
      shift_in_q <= `RST_BYTE;
      shift_out_q <= `RST_BYTE;
      read_q <= 1'b0;
      buf_q <= 1'b0;
      ind_q <= 1'b0;
      addr_q <= `RST_ADDR;
      fetch_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= {`FIFO_W{1'b0}};
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
      spi_active_q <= 1'b0;
    end else begin
      fetch_q <= 1'b0;
      push_q <= 1'b0;
      spi_active_q <= cs_act;
      if (!cs_act) begin
        // release ends the access and forgets the byte position
        state_q <= ST_IDLE;
        bit_cnt_q <= `RST_CNT;
        miso_oe_q <= 1'b0;
        miso_q <= 1'b0;
      end else if (cs_start) begin
        // status goes out while the control word comes in
        state_q <= ST_CTRL;
        bit_cnt_q <= `RST_CNT;
        shift_out_q <= top_irq_status;
        miso_q <= top_irq_status[`IRQ_W-1];
        miso_oe_q <= 1'b1;
        read_q <= 1'b0;
      end else begin
        if (sclk_rise) begin
          shift_in_q <= byte_in;
          bit_cnt_q <= bit_cnt_q + 3'h1;
        end
        if (byte_done) begin
          case (state_q)
            ST_CTRL: begin
              // control word carries direction, target and direct address
              read_q <= byte_in[`CTL_READ_BIT];
              buf_q <= byte_in[`CTL_BUF_BIT];
              ind_q <= ~byte_in[`CTL_BUF_BIT] & (byte_in[`CTL_ADDR_MSB:0] == `CTL_INDIRECT_ESC);
              addr_q <= {2'b00, byte_in[`CTL_ADDR_MSB:0]};
              if (byte_in[`CTL_BUF_BIT] || byte_in[`CTL_ADDR_MSB:0] == `CTL_INDIRECT_ESC) begin
                state_q <= ST_ADDR;
              end else begin
                state_q <= ST_DATA;
                fetch_q <= byte_in[`CTL_READ_BIT];
              end
            end
            ST_ADDR: begin
              // buffer addresses are kept inside the buffer
              addr_q <= buf_q ? {1'b0, byte_in[6:0]} : byte_in;
              state_q <= ST_DATA;
              fetch_q <= read_q;
            end
            ST_DATA: begin
              // each data byte steps the address; bursts have no length limit
              addr_q <= next_addr(addr_q, buf_q);
              if (read_q) begin
                fetch_q <= 1'b1;
              end else begin
                push_q <= 1'b1;
                push_data_q <= {buf_q, ind_q, addr_q, byte_in};
              end
            end
            default: begin
              state_q <= ST_IDLE;
            end
          endcase
        end
        if (sclk_fall) begin
          if (bit_cnt_q == `RST_CNT) begin
            // byte boundary: next byte goes on the wire
            shift_out_q <= next_out;
            miso_q <= next_out[7];
          end else begin
            shift_out_q <= {shift_out_q[6:0], 1'b0};
            miso_q <= shift_out_q[6];
          end
        end
      end
    end
  end

  // read prefetch: strobe the core or buffer, capture one or two cycles later
  // the serial half period before the next falling edge must cover this latency
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      capture_q <= 1'b0;
      capture_reg_q <= 1'b0;
      rd_data_q <= `RST_BYTE;
      reg_rd_q <= 1'b0;
      reg_rd_indirect_q <= 1'b0;
      reg_rd_addr_q <= `RST_ADDR;
    end else begin
      capture_q <= fetch_q;
      // the core answers the cycle after its registered strobe, so wait one more cycle
      capture_reg_q <= capture_q & ~buf_q;
      reg_rd_q <= fetch_q & ~buf_q;
      if (fetch_q) begin
        reg_rd_indirect_q <= ind_q;
        reg_rd_addr_q <= addr_q;
      end
      if (capture_q & buf_q) begin
        rd_data_q <= ram_rdata;
      end else if (capture_reg_q) begin
        rd_data_q <= reg_rdata;
      end
    end
  end

  // write fifo: serial writes land here; register writes drain at the core's pace, buffer writes when the buffer is free
  sync_fifo #(
    .WIDTH(`FIFO_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_wr_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // receive writes take the buffer unless protected; serial loading never blocked by protect
  assign rx_take = rx_wr_en & ~buffer_rx_protect;
  assign drain_buf = fifo_out_data[`ENT_BUF_BIT];
  // a buffer write waits for a free cycle, a register write for the core
  assign fifo_out_ready = fifo_out_valid & (drain_buf ? ~rx_take : reg_wr_ready);
  assign ram_we = rx_take | (fifo_out_ready & drain_buf);
  assign ram_waddr = rx_take ? rx_wr_addr : fifo_out_data[`ENT_ADDR_LSB+BUF_AW-1:`ENT_ADDR_LSB];
  assign ram_wdata = rx_take ? rx_wr_data : fifo_out_data[7:0];

  // register write strobe to the core, one cycle per drained register entry
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_wr_q <= 1'b0;
      reg_wr_indirect_q <= 1'b0;
      reg_wr_addr_q <= `RST_ADDR;
      reg_wr_data_q <= `RST_BYTE;
    end else begin
      reg_wr_q <= fifo_out_ready & ~drain_buf;
      if (fifo_out_ready & ~drain_buf) begin
        reg_wr_indirect_q <= fifo_out_data[`ENT_IND_BIT];
        reg_wr_addr_q <= fifo_out_data[`ENT_ADDR_MSB:`ENT_ADDR_LSB];
        reg_wr_data_q <= fifo_out_data[7:0];
      end
    end
  end

  // overrun: a write byte found the fifo full; sticky for the access
  // the serial clock cannot be held back, so the byte is lost and flagged
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overrun_q <= 1'b0;
    end else if (push_q & ~fifo_in_ready) begin
      overrun_q <= 1'b1;
    end else if (cs_start) begin
      overrun_q <= 1'b0;
    end
  end

  // shared packet buffer; lives on the always-running clock so hibernate
  // access needs nothing from the crystal domain
  byte_ram #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH),
    .AW(BUF_AW)
  ) u_pkt_buf (
    .clk(clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .re(fetch_q & buf_q),
    .raddr(addr_q[BUF_AW-1:0]),
    .rdata_q(ram_rdata)
  );

  // no power-mode input gates any path above: the port keeps working
  // whenever clk runs, which is every mode except reset

endmodule // radio_spi_slave_port

/* File: tb/radio_spi_port_monitor.sv */
`timescale 1ns/100ps

// watches the serial pins and the core strobes of the slave port
module radio_spi_port_monitor (
  // clock and reset
  input wire clk,
  input wire resetn,
  // serial pins
  input wire ssel_n,
  input wire sclk,
  input wire miso_q,
  input wire miso_oe_q,
  // core side
  input wire reg_wr_q,
  input wire reg_wr_ready,
  input wire reg_rd_q,
  input wire spi_active_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // five idle samples cover the two-flop sync plus the output register
  chk_oe_released: assert property (ssel_n [*5] |-> !miso_oe_q)
    else $error("miso enable held after deselect");
  chk_oe_selected: assert property (!ssel_n [*6] |-> miso_oe_q)
    else $error("miso not driven while selected");
  chk_active_rise: assert property ($fell(ssel_n) |-> ##[2:5] spi_active_q)
    else $error("select start not seen");
  chk_active_fall: assert property (ssel_n [*5] |-> !spi_active_q)
    else $error("select end not seen");
  chk_wr_ready: assert property (reg_wr_q |-> $past(reg_wr_ready))
    else $error("core write without ready");
  chk_rd_single: assert property (reg_rd_q |=> !reg_rd_q)
    else $error("read strobe longer than one cycle");
  chk_rd_selected: assert property (ssel_n [*8] |-> !reg_rd_q)
    else $error("read strobe outside an access");
  // data only moves after a falling edge, never deep in the high phase
  chk_miso_steady: assert property (miso_oe_q && sclk && $past(sclk) && $past(sclk, 2) |-> $stable(miso_q))
    else $error("miso moved while clock high");

  cover property (reg_wr_q && !reg_wr_ready);
  cover property (reg_rd_q);
  cover property ($rose(miso_oe_q));
endmodule // radio_spi_port_monitor

bind radio_spi_slave_port radio_spi_port_monitor i_mon (.clk(clk), .resetn(resetn), .ssel_n(ssel_n),
  .sclk(sclk), .miso_q(miso_q), .miso_oe_q(miso_oe_q), .reg_wr_q(reg_wr_q), .reg_wr_ready(reg_wr_ready),
  .reg_rd_q(reg_rd_q), .spi_active_q(spi_active_q));

/* File: tb/spi_master_model.sv */
`timescale 1ns/100ps

// behavioural serial master; its clock stands low between frames
module spi_master_model (
  // pins driven by the master
  output reg ssel_n,
  output reg sclk,
  output reg mosi,
  // slave answer
  input wire miso_q,
  input wire miso_oe_q
);
  // a released line shows the inverse of the last value, not a stale match
  wire miso_line = miso_oe_q ? miso_q : ~miso_q;

  initial begin
    ssel_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // odd offset keeps the link clock out of phase with the core clock
  task start;
    begin
      #37 ssel_n = 1'b0;
      #400;
    end
  endtask

  // msb first, mode 0, 800 ns bit time; sample late in the high phase
  task shift(input [7:0] tx, input [3:0] n, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      for (i = 0; i < n; i = i + 1) begin
        mosi = tx[7-i];
        #400 sclk = 1'b1;
        #350 rx = {rx[6:0], miso_line};
        #50 sclk = 1'b0;
      end
    end
  endtask

  // end of access; data line changes once released
  task stop;
    begin
      #400 ssel_n = 1'b1;
      mosi = ~mosi;
      #400;
    end
  endtask
endmodule // spi_master_model

/* File: tb/radio_spi_slave_port_tb.sv */
`timescale 1ns/100ps

// master model on the pins, core model on the strobes
module radio_spi_slave_port_tb;
  reg clk;
  reg resetn;
  reg [7:0] top_irq_status;
  reg reg_wr_ready;
  reg [7:0] reg_rdata;
  reg buffer_rx_protect;
  reg rx_wr_en;
  reg [6:0] rx_wr_addr;
  reg [7:0] rx_wr_data;
  wire ssel_n, sclk, mosi, miso_q, miso_oe_q;
  wire reg_wr_q, reg_wr_indirect_q, reg_rd_q, reg_rd_indirect_q, overrun_q, spi_active_q;
  wire [7:0] reg_wr_addr_q, reg_wr_data_q, reg_rd_addr_q;
  reg [16:0] wq [$]; // core writes seen, {indirect, addr, data}
  reg [16:0] ent;
  reg [7:0] rx;
  reg [6:0] a;
  integer n_fail, samples_checked, i;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  radio_spi_slave_port i_dut (.clk(clk), .resetn(resetn), .ssel_n(ssel_n), .sclk(sclk), .mosi(mosi),
    .miso_q(miso_q), .miso_oe_q(miso_oe_q), .top_irq_status(top_irq_status), .reg_wr_q(reg_wr_q),
    .reg_wr_indirect_q(reg_wr_indirect_q), .reg_wr_addr_q(reg_wr_addr_q), .reg_wr_data_q(reg_wr_data_q),
    .reg_wr_ready(reg_wr_ready), .reg_rd_q(reg_rd_q), .reg_rd_indirect_q(reg_rd_indirect_q),
    .reg_rd_addr_q(reg_rd_addr_q), .reg_rdata(reg_rdata), .buffer_rx_protect(buffer_rx_protect),
    .rx_wr_en(rx_wr_en), .rx_wr_addr(rx_wr_addr), .rx_wr_data(rx_wr_data), .overrun_q(overrun_q),
    .spi_active_q(spi_active_q));
  spi_master_model i_master (.ssel_n(ssel_n), .sclk(sclk), .mosi(mosi), .miso_q(miso_q),
    .miso_oe_q(miso_oe_q));

  // core register contents: a fixed function of space and address
  function [7:0] core_val(input ind, input [7:0] ad);
    core_val = ad ^ (ind ? 8'hC3 : 8'h5A);
  endfunction

  // read data lands the cycle after the strobe; writes are queued for checking
  always @(posedge clk) begin
    if (reg_rd_q === 1'b1)
      reg_rdata <= core_val(reg_rd_indirect_q, reg_rd_addr_q);
    if (reg_wr_q === 1'b1)
      wq.push_back({reg_wr_indirect_q, reg_wr_addr_q, reg_wr_data_q});
  end

  task tally_and_finish;
    begin
      if (n_fail == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task cmp_byte(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  // one byte on the link, answer compared
  task xc(input [7:0] tx, input [7:0] exp);
    begin
      i_master.shift(tx, 4'h8, rx);
      cmp_byte(rx, exp);
    end
  endtask

  // next core write compared; a long silence ends the run
  task check_wr(input [16:0] exp);
    integer t;
    begin
      for (t = 0; t < 300 && wq.size() == 0; t = t + 1)
        @(posedge clk);
      if (wq.size() == 0) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: no core write", $time);
        tally_and_finish;
      end else begin
        ent = wq.pop_front();
        samples_checked = samples_checked + 1;
        if (ent !== exp) begin
          n_fail = n_fail + 1;
          $display("wrong value at %0t: write %h want %h", $time, ent, exp);
        end
      end
    end
  endtask

  // core-side inputs change one step after the edge
  task set_in(input rdy, input prot, input [7:0] st);
    begin
      @(posedge clk);
      #1 reg_wr_ready = rdy;
      buffer_rx_protect = prot;
      top_irq_status = st;
    end
  endtask

  task rx_write(input [6:0] ad, input [7:0] d);
    begin
      @(posedge clk);
      #1 rx_wr_en = 1'b1;
      rx_wr_addr = ad;
      rx_wr_data = d;
      @(posedge clk);
      #1 rx_wr_en = 1'b0;
    end
  endtask

  // single-byte buffer accesses; address bytes answer zero
  task buf_acc(input rd, input [6:0] ad, input [7:0] d);
    begin
      i_master.start;
      xc({rd, 7'h40}, top_irq_status);
      xc({1'b0, ad}, 8'h00);
      xc(rd ? 8'h00 : d, rd ? d : 8'h00);
      i_master.stop;
    end
  endtask

  task s_direct;
    begin
      set_in(1'b1, 1'b0, 8'h96);
      i_master.start;
      xc(8'h05, 8'h96);
      xc(8'hA5, 8'h00);
      i_master.stop;
      check_wr({1'b0, 8'h05, 8'hA5});
      cmp_byte({7'h00, miso_oe_q}, 8'h00);
      set_in(1'b1, 1'b0, 8'h3C);
      i_master.start;
      xc(8'h90, 8'h3C);
      for (i = 0; i < 3; i = i + 1)
        xc(8'h00, core_val(1'b0, 8'h10 + i[7:0]));
      i_master.stop;
    end
  endtask

  task s_indirect;
    begin
      i_master.start;
      xc(8'h3F, 8'h3C);
      xc(8'h42, 8'h00);
      xc(8'h77, 8'h00);
      i_master.stop;
      check_wr({1'b1, 8'h42, 8'h77});
      i_master.start;
      xc(8'hBF, 8'h3C);
      xc(8'h43, 8'h00);
      xc(8'h00, core_val(1'b1, 8'h43));
      xc(8'h00, core_val(1'b1, 8'h44));
      i_master.stop;
    end
  endtask

  // whole buffer in one burst, read back from the top so it wraps
  task s_buffer;
    begin
      i_master.start;
      xc(8'h40, 8'h3C);
      xc(8'h00, 8'h00);
      for (i = 0; i < 128; i = i + 1)
        xc(i[7:0] ^ 8'h3C, 8'h00);
      i_master.stop;
      i_master.start;
      xc(8'hC0, 8'h3C);
      xc(8'h7F, 8'h00);
      for (i = 0; i < 129; i = i + 1) begin
        a = 7'h7F + i[6:0];
        xc(8'h00, {1'b0, a} ^ 8'h3C);
      end
      i_master.stop;
    end
  endtask

  task s_protect;
    begin
      set_in(1'b1, 1'b1, 8'h3C);
      rx_write(7'h05, 8'hEE);
      buf_acc(1'b1, 7'h05, 8'h39);
      buf_acc(1'b0, 7'h05, 8'h99);
      buf_acc(1'b1, 7'h05, 8'h99);
      set_in(1'b1, 1'b0, 8'h3C);
      rx_write(7'h06, 8'hEE);
      buf_acc(1'b1, 7'h06, 8'hEE);
    end
  endtask

  // core stalls: sixteen writes fit, the rest are flagged and lost
  task s_overrun;
    begin
      set_in(1'b0, 1'b0, 8'h3C);
      i_master.start;
      xc(8'h20, 8'h3C);
      for (i = 0; i < 18; i = i + 1)
        xc(i[7:0], 8'h00);
      i_master.stop;
      cmp_byte({7'h00, overrun_q}, 8'h01);
      set_in(1'b1, 1'b0, 8'h3C);
      for (i = 0; i < 16; i = i + 1)
        check_wr({1'b0, 8'h20 + i[7:0], i[7:0]});
    end
  endtask

  // half a control word then release: nothing of it survives
  task s_abort;
    begin
      i_master.start;
      i_master.shift(8'hAA, 4'h4, rx);
      i_master.stop;
      cmp_byte({7'h00, overrun_q}, 8'h00);
      i_master.start;
      xc(8'h07, 8'h3C);
      xc(8'h11, 8'h00);
      i_master.stop;
      check_wr({1'b0, 8'h07, 8'h11});
      repeat (100) @(posedge clk);
      cmp_byte(8'(wq.size()), 8'h00);
    end
  endtask

  initial begin
    n_fail = 0;
    samples_checked = 0;
    resetn = 1'b0;
    top_irq_status = 8'h00;
    reg_wr_ready = 1'b1;
    buffer_rx_protect = 1'b0;
    rx_wr_en = 1'b0;
    rx_wr_addr = 7'h00;
    rx_wr_data = 8'h00;
    repeat (3) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk);
    s_direct;
    s_indirect;
    s_buffer;
    s_protect;
    s_overrun;
    s_abort;
    tally_and_finish;
  end
endmodule // radio_spi_slave_port_tb
